// ===== hdl/sair_area_rom.sv
// table of accessible memory areas, looked up by area index
`timescale 1ns/1ps
`default_nettype none
module sair_area_rom
  import sair_pkg::*;
(
  // lookup
  input  wire logic [7:0] index_in,
  output sair_area_t      area_out
);

  localparam int N_AREAS = 3;

  // a unit of zero marks the matching operation as unsupported on that area
  localparam sair_area_t TABLE [N_AREAS] = '{
    '{{KIND_USER, 4'h0},   32'h0000_0000, 32'h0000_FFFF,
      32'h0000_1000, 32'h0000_0080, 32'h0000_0001, 32'h0000_0400},
    '{{KIND_DATA, 4'h0},   32'h1000_0000, 32'h1000_0FFF,
      32'h0000_0040, 32'h0000_0004, 32'h0000_0001, 32'h0000_0400},
    '{{KIND_CONFIG, 4'h0}, 32'h2000_0000, 32'h2000_007F,
      32'h0000_0000, 32'h0000_0010, 32'h0000_0001, 32'h0000_0080}
  };

  // indices past the table answer zeros; the responder refuses them anyway
  always_comb
  begin
    area_out = '0;
    if (index_in < AREA_COUNT)
      area_out = TABLE[index_in[1:0]];
  end

endmodule
`default_nettype wire

// ===== hdl/sair_fifo2.sv
// two-entry skid buffer between the reply generator and the transmitter
`timescale 1ns/1ps
`default_nettype none
module sair_fifo2
  import sair_pkg::*;
#(
  parameter int WIDTH = 8
)(
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  // filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  typedef struct packed {
    logic             head_v;
    logic [WIDTH-1:0] head;
    logic             tail_v;
    logic [WIDTH-1:0] tail;
  } sair_fifo_t;

  sair_fifo_t s;
  sair_fifo_t next_s;
  logic       push;
  logic       pop;

  // head always holds the older word, so the output is a plain flop
  always_comb
  begin
    next_s = s;
    push   = in_valid_in & ~s.tail_v;
    pop    = s.head_v & out_ready_in;
    if (pop)
    begin
      next_s.head_v = s.tail_v;
      next_s.head   = s.tail;
      next_s.tail_v = 1'b0;
    end
    if (push)
    begin
      if (!next_s.head_v)
      begin
        next_s.head_v = 1'b1;
        next_s.head   = in_data_in;
      end
      else
      begin
        next_s.tail_v = 1'b1;
        next_s.tail   = in_data_in;
      end
    end
    if (srst_in)
      next_s = '0;
  end

  always_ff @(posedge ref_clk_in)
    s <= next_s;

  // ready falls only when both entries hold a word
  assign in_ready_out  = ~s.tail_v;
  assign out_valid_out = s.head_v;
  assign out_data_out  = s.head;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  stall_keeps_word_a: assert property ((push && !pop && s.head_v) |=> (s.tail_v && s.tail == $past(in_data_in)))
    else $error("word pushed into a busy buffer was not kept");
  order_kept_a: assert property ((pop && s.tail_v) |=> (s.head_v && s.head == $past(s.tail)))
    else $error("older word did not move to the head");

endmodule
`default_nettype wire

// ===== hdl/sair_pkg.sv
// shared constants and types of the signature and area information responder
package sair_pkg;

  // packet framing bytes
  localparam logic [7:0]  CMD_START    = 8'h01;
  localparam logic [7:0]  PKT_END      = 8'h03;
  localparam logic [7:0]  REPLY_START  = 8'h81;
  localparam logic [7:0]  LEN_HI_REPLY = 8'h00;
  localparam logic [7:0]  ERR_FLAG     = 8'h80;
  localparam logic [7:0]  SPACE_CODE   = 8'h20;

  // command codes and their fixed lengths
  localparam logic [7:0]  CMD_SIG      = 8'h3A;
  localparam logic [7:0]  CMD_AREA     = 8'h3B;
  localparam logic [15:0] SIG_CMD_LEN  = 16'h0001;
  localparam logic [15:0] AREA_CMD_LEN = 16'h0002;
  localparam logic [15:0] MAX_CMD_LEN  = 16'h0401;

  // reply length low bytes and layout counts
  localparam logic [7:0]  SIG_LNL      = 8'h2A;
  localparam logic [7:0]  AREA_LNL     = 8'h1A;
  localparam logic [7:0]  ERR_LNL      = 8'h0A;
  localparam logic [7:0]  HDR_BYTES    = 8'h03;
  localparam logic [7:0]  TAIL_SUM_OFS = 8'h03;
  localparam logic [7:0]  TAIL_END_OFS = 8'h04;
  localparam int          BODY_BYTES   = 42;

  // status codes carried in error replies
  localparam logic [7:0]  STS_PACKET   = 8'hC1;
  localparam logic [7:0]  STS_CHECKSUM = 8'hC2;
  localparam logic [7:0]  STS_ACCEPT   = 8'hC3;
  localparam logic [7:0]  STS_PARAM    = 8'hC4;
  localparam logic [31:0] UNUSED_WORD  = 32'hFFFF_FFFF;

  // signature contents
  localparam logic [31:0]  MAX_BAUD_DEFAULT  = 32'h000F_4240;
  localparam logic [7:0]   AREA_COUNT        = 8'h03;
  localparam logic [7:0]   FEATURE_CLASS_DEF = 8'h5A;   // arbitrary value
  localparam logic [23:0]  FW_VERSION_DEF    = 24'h01_0000;
  localparam logic [127:0] PRODUCT_NAME_DEF  = {"DEVICE", {10{SPACE_CODE}}};

  // area kinds, upper nibble of the kind byte
  localparam logic [3:0]  KIND_USER    = 4'h0;
  localparam logic [3:0]  KIND_DATA    = 4'h1;
  localparam logic [3:0]  KIND_CONFIG  = 4'h2;
  localparam logic [3:0]  KIND_NVCFG   = 4'h3;
  localparam logic [3:0]  KIND_EXTMEM  = 4'h4;

  typedef struct packed {
    logic [7:0]  area_kind;
    logic [31:0] area_start;
    logic [31:0] area_end;
    logic [31:0] erase_unit;
    logic [31:0] write_unit;
    logic [31:0] read_unit;
    logic [31:0] crc_unit;
  } sair_area_t;

  typedef enum logic [2:0] {
    ST_WAIT, ST_LNH, ST_LNL, ST_BODY, ST_SUM, ST_ETX, ST_SEND
  } sair_state_t;

  typedef enum logic [1:0] {
    REPLY_SIG, REPLY_AREA, REPLY_ERR
  } sair_reply_t;

endpackage

// ===== hdl/sair_responder.sv
// serial command handler for the signature and area information queries
`timescale 1ns/1ps
`default_nettype none
module sair_responder
  import sair_pkg::*;
#(
  parameter logic [31:0]  MAX_BAUD      = MAX_BAUD_DEFAULT,
  parameter logic [7:0]   FEATURE_CLASS = FEATURE_CLASS_DEF,   // arbitrary value
  parameter logic [23:0]  FW_VERSION    = FW_VERSION_DEF,
  parameter logic [127:0] PRODUCT_NAME  = PRODUCT_NAME_DEF
)(
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         srst_in,
  // command bytes from the link
  input  wire logic         rx_valid_in,
  input  wire logic [7:0]   rx_data_in,
  output logic              rx_ready_out,
  // reply bytes to the link
  output logic              tx_valid_out,
  output logic [7:0]        tx_data_out,
  input  wire logic         tx_ready_in,
  // device state
  input  wire logic         enc_write_pending_in,
  input  wire logic [127:0] chip_id_in,
  output logic              busy_out
);

  typedef struct packed {
    sair_state_t state;
    logic        rx_rdy;
    logic        busy;
    logic [15:0] len;
    logic [15:0] cnt;
    logic [7:0]  sum;
    logic        sum_ok;
    logic [7:0]  cmd;
    logic [7:0]  arg;
    sair_reply_t kind;
    logic [7:0]  res;
    logic [7:0]  sts;
    logic [7:0]  length_low_byte;
    logic [7:0]  idx;
    logic [7:0]  tx_sum;
  } sair_core_t;

  localparam sair_core_t CORE_RESET = '{state: ST_WAIT, kind: REPLY_ERR, default: '0};

  sair_core_t                  s;
  sair_core_t                  next_s;
  sair_area_t                  area;
  logic                        rx_take;
  logic                        known;
  logic [15:0]                 want_len;
  logic                        fifo_ready;
  logic                        tx_push;
  logic [7:0]                  tx_byte;
  logic [7:0]                  body_byte;
  logic [7:0]                  body_idx;
  logic [BODY_BYTES*8-1:0]     body;
  logic [BODY_BYTES*8-1:0]     body_shift;

  sair_area_rom u_area_rom (
    .index_in (s.arg),
    .area_out (area)
  );

  // request decode used by the end-of-packet evaluation
  assign rx_take  = rx_valid_in & s.rx_rdy;
  assign known    = (s.len != 16'h0000) && ((s.cmd == CMD_SIG) || (s.cmd == CMD_AREA));
  assign want_len = (s.cmd == CMD_SIG) ? SIG_CMD_LEN : AREA_CMD_LEN;

  // reply payload, first byte in the top bits; unused tail is zero
  always_comb
  begin
    body = '0;
    unique case (s.kind)
      REPLY_SIG:
        body = {CMD_SIG, MAX_BAUD, AREA_COUNT, FEATURE_CLASS,
                FW_VERSION, chip_id_in, PRODUCT_NAME};
      REPLY_AREA:
        body = {CMD_AREA, area, {16{8'h00}}};
      REPLY_ERR:
        body = {s.res, s.sts, UNUSED_WORD, UNUSED_WORD, {32{8'h00}}};
    endcase
    body_idx   = 8'(s.idx - HDR_BYTES);
    body_shift = body << {body_idx, 3'b000};
    body_byte  = body_shift[BODY_BYTES*8-1 -: 8];
  end

  // reply byte for the current position in the outgoing packet
  always_comb
  begin
    if (s.idx == 8'h00)
      tx_byte = REPLY_START;
    else if (s.idx == 8'h01)
      tx_byte = LEN_HI_REPLY;
    else if (s.idx == 8'h02)
      tx_byte = s.length_low_byte;
    else if (s.idx == 8'(s.length_low_byte + TAIL_SUM_OFS))
      tx_byte = 8'(8'h00 - s.tx_sum);
    else if (s.idx == 8'(s.length_low_byte + TAIL_END_OFS))
      tx_byte = PKT_END;
    else
      tx_byte = body_byte;
  end

  assign tx_push = (s.state == ST_SEND) & fifo_ready;

  // receive, check and answer; one packet at a time, no overlap
  always_comb
  begin
    next_s = s;
    unique case (s.state)
      ST_WAIT:
        if (rx_take && rx_data_in == CMD_START)
        begin
          next_s.state = ST_LNH;
          next_s.sum   = 8'h00;
        end
      ST_LNH:
        if (rx_take)
        begin
          next_s.len[15:8] = rx_data_in;
          next_s.sum       = 8'(s.sum + rx_data_in);
          next_s.state     = ST_LNL;
        end
      ST_LNL:
        if (rx_take)
        begin
          next_s.len[7:0] = rx_data_in;
          next_s.sum      = 8'(s.sum + rx_data_in);
          next_s.cnt      = 16'h0000;
          next_s.cmd      = 8'h00;
          next_s.arg      = 8'h00;
          // an empty packet goes straight to its check byte
          next_s.state    = ({s.len[15:8], rx_data_in} == 16'h0000) ? ST_SUM : ST_BODY;
        end
      ST_BODY:
        if (rx_take)
        begin
          if (s.cnt == 16'h0000)
            next_s.cmd = rx_data_in;
          if (s.cnt == 16'h0001)
            next_s.arg = rx_data_in;
          next_s.sum = 8'(s.sum + rx_data_in);
          next_s.cnt = 16'(s.cnt + 16'h0001);
          if (next_s.cnt == s.len)
            next_s.state = ST_SUM;
        end
      ST_SUM:
        if (rx_take)
        begin
          next_s.sum_ok = (8'(s.sum + rx_data_in) == 8'h00);
          next_s.state  = ST_ETX;
        end
      ST_ETX:
        if (rx_take)
        begin
          // codes of other handlers are left alone
          next_s.state  = ST_WAIT;
          next_s.idx    = 8'h00;
          next_s.tx_sum = 8'h00;
          next_s.kind   = REPLY_ERR;
          next_s.length_low_byte    = ERR_LNL;
          next_s.res    = s.cmd | ERR_FLAG;
          if (known)
          begin
            next_s.state = ST_SEND;
            // first failing check wins; nothing else happens on an error
            if (rx_data_in != PKT_END)
              next_s.sts = STS_PACKET;
            else if (!s.sum_ok)
              next_s.sts = STS_CHECKSUM;
            else if (s.len > MAX_CMD_LEN)
              next_s.sts = STS_PACKET;
            else if (s.len != want_len)
              next_s.sts = STS_PACKET;
            else if (enc_write_pending_in)
              next_s.sts = STS_ACCEPT;
            else if (s.cmd == CMD_AREA && s.arg >= AREA_COUNT)
              next_s.sts = STS_PARAM;
            else
            begin
              next_s.res  = s.cmd;
              next_s.kind = (s.cmd == CMD_SIG) ? REPLY_SIG : REPLY_AREA;
              next_s.length_low_byte  = (s.cmd == CMD_SIG) ? SIG_LNL : AREA_LNL;
            end
          end
        end
      ST_SEND:
        if (tx_push)
        begin
          next_s.idx = 8'(s.idx + 8'h01);
          if (s.idx != 8'h00 && s.idx < 8'(s.length_low_byte + TAIL_SUM_OFS))
            next_s.tx_sum = 8'(s.tx_sum + tx_byte);
          if (s.idx == 8'(s.length_low_byte + TAIL_END_OFS))
            next_s.state = ST_WAIT;
        end
    endcase
    // input is held off while a reply is queued, so no command byte is lost
    next_s.rx_rdy = (next_s.state != ST_SEND);
    next_s.busy   = (next_s.state != ST_WAIT);
    if (srst_in)
      next_s = CORE_RESET;
  end

  always_ff @(posedge ref_clk_in)
    s <= next_s;

  sair_fifo2 #(
    .WIDTH (8)
  ) u_tx_buf (
    .ref_clk_in    (ref_clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (tx_push),
    .in_data_in    (tx_byte),
    .in_ready_out  (fifo_ready),
    .out_valid_out (tx_valid_out),
    .out_data_out  (tx_data_out),
    .out_ready_in  (tx_ready_in)
  );

  assign rx_ready_out = s.rx_rdy;
  assign busy_out     = s.busy;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence etx_seen;
    s.state == ST_ETX && rx_take && known && rx_data_in == PKT_END;
  endsequence

  sequence err_reply(logic [7:0] code);
    s.state == ST_SEND && s.kind == REPLY_ERR && s.sts == code && s.length_low_byte == ERR_LNL;
  endsequence

  soh_hunt_a: assert property ((s.state == ST_WAIT && rx_take && rx_data_in != CMD_START) |=> s.state == ST_WAIT)
    else $error("non start byte left the hunt state");
  end_missing_a: assert property ((s.state == ST_ETX && rx_take && known && rx_data_in != PKT_END) |=> err_reply(STS_PACKET))
    else $error("missing end marker not reported as packet error");
  sum_wrong_a: assert property ((etx_seen and (!s.sum_ok)) |=> err_reply(STS_CHECKSUM))
    else $error("bad check byte not reported as checksum error");
  len_wrong_a: assert property ((etx_seen and (s.sum_ok && s.len != want_len)) |=> err_reply(STS_PACKET))
    else $error("wrong length not reported as packet error");
  accept_err_a: assert property ((etx_seen and (s.sum_ok && s.len == want_len && enc_write_pending_in))
                                 |=> err_reply(STS_ACCEPT))
    else $error("pending encrypted write not refused");
  area_param_a: assert property ((etx_seen and (s.sum_ok && s.len == AREA_CMD_LEN && s.cmd == CMD_AREA &&
                                 !enc_write_pending_in && s.arg >= AREA_COUNT)) |=> err_reply(STS_PARAM))
    else $error("area index out of range not refused");
  unknown_drop_a: assert property ((s.state == ST_ETX && rx_take && !known) |=> s.state == ST_WAIT)
    else $error("foreign command was answered");
  reply_head_a: assert property ((tx_push && s.idx == 8'h00) |-> (tx_byte == REPLY_START) ##1
                                 (s.state == ST_SEND && tx_byte == LEN_HI_REPLY)[*1])
    else $error("reply does not open with marker and length");
  sig_len_a: assert property ((s.state == ST_SEND && s.kind == REPLY_SIG) |-> s.length_low_byte == SIG_LNL && s.res == CMD_SIG)
    else $error("signature reply has wrong length or code");
  baud_first_a: assert property ((tx_push && s.kind == REPLY_SIG && s.idx == 8'h04) |-> tx_byte == MAX_BAUD[31:24])
    else $error("baud field not sent high byte first");
  kind_byte_a: assert property ((tx_push && s.kind == REPLY_AREA && s.idx == 8'h04) |-> tx_byte == area.area_kind)
    else $error("area kind byte misplaced");
  sum_zero_a: assert property ((tx_push && s.idx == 8'(s.length_low_byte + TAIL_SUM_OFS)) |-> 8'(tx_byte + s.tx_sum) == 8'h00)
    else $error("reply check byte does not zero the sum");
  reply_end_a: assert property ((tx_push && s.idx == 8'(s.length_low_byte + TAIL_END_OFS)) |-> tx_byte == PKT_END ##1
                                s.state == ST_WAIT && s.rx_rdy)
    else $error("reply does not end with end marker and hunt");

endmodule
`default_nettype wire

// ===== tb/sair_host_model.sv
// host tool model: sends command packets and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module sair_host_model
  import sair_pkg::*;
(
  // clock
  input  wire logic       ref_clk_in,
  // command link
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  input  wire logic       rx_ready_in,
  // reply link
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out
);
  logic [7:0] got[$];
  logic       slow;
  int         fails;
  int         ph;

  initial
  begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b0;
    slow         = 1'b0;
    fails        = 0;
    ph           = 0;
  end

  // slow mode takes one byte in three, so the reply buffer must hold back
  always @(negedge ref_clk_in)
  begin
    ph = (ph + 1) % 3;
    tx_ready_out <= !slow || ph == 0;
  end

  // every reply byte taken by the link
  always @(posedge ref_clk_in)
    if (tx_valid_in && tx_ready_out)
      got.push_back(tx_data_in);

  // each byte held until an edge sees ready; idle data shows the inverse of the last
  task automatic send(input logic [7:0] b[$]);
    int n;
    foreach (b[i])
    begin
      @(negedge ref_clk_in);
      rx_valid_out <= 1'b1;
      rx_data_out  <= b[i];
      n = 0;
      do
      begin
        @(posedge ref_clk_in);
        n++;
      end
      while (rx_ready_in !== 1'b1 && n < 200);
      if (n >= 200)
        fails++;
    end
    @(negedge ref_clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~rx_data_out;
  endtask
endmodule
`default_nettype wire

// ===== tb/sair_responder_bench.sv
// self-checking bench of the signature and area information responder
`timescale 1ns/1ps
`default_nettype none
module sair_responder_bench
  import sair_pkg::*;
;
  localparam logic [127:0] CHIP_ID = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;

  logic         ref_clk;
  logic         srst;
  logic         rx_valid;
  logic [7:0]   rx_data;
  logic         rx_ready;
  logic         tx_valid;
  logic [7:0]   tx_data;
  logic         tx_ready;
  logic         enc;
  logic         busy;
  int           err_count;
  int           checked;
  logic [7:0]   pkt[$];
  logic [7:0]   exp[$];
  logic [7:0]   pay[$];
  logic [7:0]   big[$];
  logic [7:0]   nil[$];
  sair_area_t   areas[3] = '{
    {8'h00, 32'h0000_0000, 32'h0000_FFFF, 32'h0000_1000, 32'h0000_0080, 32'h0000_0001, 32'h0000_0400},
    {8'h10, 32'h1000_0000, 32'h1000_0FFF, 32'h0000_0040, 32'h0000_0004, 32'h0000_0001, 32'h0000_0400},
    {8'h20, 32'h2000_0000, 32'h2000_007F, 32'h0000_0000, 32'h0000_0010, 32'h0000_0001, 32'h0000_0080}};

  sair_responder DUT (
    .ref_clk_in           (ref_clk),
    .srst_in              (srst),
    .rx_valid_in          (rx_valid),
    .rx_data_in           (rx_data),
    .rx_ready_out         (rx_ready),
    .tx_valid_out         (tx_valid),
    .tx_data_out          (tx_data),
    .tx_ready_in          (tx_ready),
    .enc_write_pending_in (enc),
    .chip_id_in           (CHIP_ID),
    .busy_out             (busy)
  );

  sair_host_model host (
    .ref_clk_in   (ref_clk),
    .rx_valid_out (rx_valid),
    .rx_data_out  (rx_data),
    .rx_ready_in  (rx_ready),
    .tx_valid_in  (tx_valid),
    .tx_data_in   (tx_data),
    .tx_ready_out (tx_ready)
  );

  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // verdict, reached from the main sequence or from run on a spent wait or a reply of the wrong size
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
    checked++;
    if (got !== want)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  // fill pay with the low n bytes of v, high byte first
  task automatic bytes_of(input logic [327:0] v, input int n);
    pay.delete();
    for (int i = n - 1; i >= 0; i--)
      pay.push_back(v[i*8 +: 8]);
  endtask

  // command packet behind two noise bytes; sx spoils the check byte, eb is the end byte
  task automatic mk_cmd(input logic [15:0] len, input logic [7:0] body[$], input logic [7:0] sx,
                        input logic [7:0] eb);
    logic [7:0] s;
    s = len[15:8] + len[7:0];
    foreach (body[i])
      s += body[i];
    pkt = {8'hAA, PKT_END, CMD_START, len[15:8], len[7:0]};
    pkt = {pkt, body, (8'h00 - s) ^ sx, eb};
  endtask

  // reply frame: length counts reply code and payload
  task automatic mk_reply(input logic [7:0] res);
    logic [7:0] s;
    logic [7:0] length_low_byte;
    length_low_byte = 8'(pay.size() + 1);
    s   = length_low_byte + res;
    foreach (pay[i])
      s += pay[i];
    exp = {REPLY_START, LEN_HI_REPLY, length_low_byte, res, pay, 8'h00 - s, PKT_END};
  endtask

  // send pkt, collect the reply, compare it and see the hunt resume
  task automatic run(input string name);
    int n;
    host.got.delete();
    host.send(pkt);
    n = 0;
    while (host.got.size() < exp.size() && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (20) @(posedge ref_clk);  // room for stray extra bytes
    checked++;
    if (n >= 2000 || host.fails != 0 || host.got.size() != exp.size())
    begin
      err_count++;
      $display("unexpected at %0t: %s reply of %0d bytes", $time, name, host.got.size());
      complete_run();
    end
    foreach (exp[i])
      check(host.got[i], exp[i], name);
    check({6'h00, busy, rx_ready}, 8'h01, name);
    $display("test %s done", name);
  endtask

  task automatic t_sig();
    host.slow = 1'b1;
    mk_cmd(SIG_CMD_LEN, '{CMD_SIG}, 8'h00, PKT_END);
    bytes_of({MAX_BAUD_DEFAULT, AREA_COUNT, FEATURE_CLASS_DEF, FW_VERSION_DEF, CHIP_ID, PRODUCT_NAME_DEF}, 41);
    mk_reply(CMD_SIG);
    run("signature");
    host.slow = 1'b0;
  endtask

  task automatic t_area(input int i);
    logic [31:0] start;
    logic [31:0] wu;
    mk_cmd(AREA_CMD_LEN, '{CMD_AREA, 8'(i)}, 8'h00, PKT_END);
    bytes_of(areas[i], 25);
    mk_reply(CMD_AREA);
    run("area");
    // the host aligns later addresses to the reported write unit, so the start must sit on it
    start = {host.got[5], host.got[6], host.got[7], host.got[8]};
    wu    = {host.got[17], host.got[18], host.got[19], host.got[20]};
    check({7'h00, wu == 32'h0000_0000 || (start % wu) != 32'h0000_0000}, 8'h00, "alignment");
  endtask

  // error reply: status, then two all-ones words
  task automatic t_err(input logic [15:0] len, input logic [7:0] body[$], input logic [7:0] sx,
                       input logic [7:0] eb, input logic en, input logic [7:0] sts);
    @(negedge ref_clk);
    enc = en;
    mk_cmd(len, body, sx, eb);
    bytes_of({sts, UNUSED_WORD, UNUSED_WORD}, 9);
    mk_reply(body[0] | ERR_FLAG);
    run("error");
  endtask

  // packets left to other handlers: no reply at all, hunt resumes
  task automatic t_drop(input logic [15:0] len, input logic [7:0] body[$]);
    mk_cmd(len, body, 8'h00, PKT_END);
    exp.delete();
    run("dropped");
  endtask

  // reset inside a packet: the hunt restarts and the next query is answered
  task automatic t_reset();
    pkt = {CMD_START, 8'h00};
    host.send(pkt);
    check({7'h00, busy}, 8'h01, "inside packet");
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    check({6'h00, busy, rx_ready}, 8'h01, "reset in packet");
    $display("test reset done");
  endtask

  initial
  begin
    srst      = 1'b1;
    enc       = 1'b0;
    err_count = 0;
    checked   = 0;
    repeat (6) @(negedge ref_clk);
    check({5'h00, busy, rx_ready, tx_valid}, 8'h00, "reset");
    srst = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_sig();
    for (int i = 0; i < 3; i++)
      t_area(i);
    t_err(SIG_CMD_LEN, '{CMD_SIG}, 8'h00, 8'h00, 1'b0, STS_PACKET);
    t_err(SIG_CMD_LEN, '{CMD_SIG}, 8'h01, 8'h00, 1'b0, STS_PACKET);
    t_err(SIG_CMD_LEN, '{CMD_SIG}, 8'h01, PKT_END, 1'b0, STS_CHECKSUM);
    t_err(16'h0002, '{CMD_SIG, 8'h00}, 8'h01, PKT_END, 1'b1, STS_CHECKSUM);
    t_err(16'h0002, '{CMD_SIG, 8'h00}, 8'h00, PKT_END, 1'b1, STS_PACKET);
    t_err(16'h0001, '{CMD_AREA}, 8'h00, PKT_END, 1'b0, STS_PACKET);
    big = {CMD_SIG};
    repeat (1025) big.push_back(8'h00);
    t_err(MAX_CMD_LEN + 16'h0001, big, 8'h00, PKT_END, 1'b0, STS_PACKET);
    t_err(SIG_CMD_LEN, '{CMD_SIG}, 8'h00, PKT_END, 1'b1, STS_ACCEPT);
    t_err(AREA_CMD_LEN, '{CMD_AREA, AREA_COUNT}, 8'h00, PKT_END, 1'b1, STS_ACCEPT);
    t_err(AREA_CMD_LEN, '{CMD_AREA, AREA_COUNT}, 8'h00, PKT_END, 1'b0, STS_PARAM);
    t_err(AREA_CMD_LEN, '{CMD_AREA, 8'hFF}, 8'h00, PKT_END, 1'b0, STS_PARAM);
    t_drop(SIG_CMD_LEN, '{8'h00});
    t_drop(16'h0000, nil);
    t_reset();
    t_area(2);
    complete_run();
  end
endmodule
`default_nettype wire
